// File: include/dwg_pkg.sv
// Package of the waveform parameter block: register map, field layouts, modes, timing.
// Assumes a 200 MHz system clock and a synchronous internal register port.
package dwg_pkg;

  // ---------------------------------------------------------------
  // Register offsets and field layouts
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_RAMP2_TIME   = 16'h202C;
  localparam logic [15:0] ADDR_FREQ_WORD    = 16'h2030;
  localparam logic [15:0] ADDR_PHASE_OFFSET = 16'h2034;
  localparam logic [15:0] ADDR_DC_OFFSET    = 16'h2038;
  localparam int RAMP2_W   = 20;
  localparam int FREQ_W    = 24;
  localparam int PHASE_W   = 20;
  localparam int OFFSET_W  = 12;
  localparam int GAIN_W    = 11;
  localparam int ACC_W     = 30;
  localparam int CODE_W    = 12;
  localparam logic [RAMP2_W-1:0]  RST_RAMP2  = 20'h00000;
  localparam logic [FREQ_W-1:0]   RST_FREQ   = 24'h000000;
  localparam logic [PHASE_W-1:0]  RST_PHASE  = 20'h00000;
  localparam logic [OFFSET_W-1:0] RST_OFFSET = 12'h000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ    = 200_000_000;
  localparam int TRAP_RATE_HZ  = 320_000;
  localparam int TRAP_TICK_CYC = SYS_CLK_HZ / TRAP_RATE_HZ;

  // Waveform type selection codes; 2'b01 is not a defined code.
  typedef enum logic [1:0] {
    WAVE_DIRECT = 2'b00,
    WAVE_SINE   = 2'b10,
    WAVE_TRAP   = 2'b11
  } dwg_wave_t;

  // One sample word on its way to the converter.
  typedef struct packed {
    logic [1:0]               src;
    logic signed [CODE_W-1:0] code;
  } dwg_sample_t;

endpackage : dwg_pkg

// File: rtl/dwg_top.sv
// Waveform generator parameter registers, sine and trapezoid sample sources and output buffer.
// Assumes all inputs except the reset come from logic on clk_sys_in and the converter
// drains samples through a valid/ready handshake.
`timescale 1ns/1ps
module dwg_top
  import dwg_pkg::*;
(
  input  wire logic                clk_sys_in,            // System clock, 200 MHz.
  input  wire logic                resetn_in,             // Asynchronous reset, active low.
  input  wire logic                reg_wr_in,             // Register write strobe.
  input  wire logic                reg_rd_in,             // Register read strobe.
  input  wire logic [15:0]         reg_addr_in,           // Register byte address.
  input  wire logic [31:0]         reg_wdata_in,          // Register write data.
  output logic      [31:0]         reg_rdata_out,         // Register read data, one cycle later.
  input  wire logic [1:0]          waveform_type_select_in, // Waveform type code.
  input  wire logic                generator_enable_in,   // Enable from the front-end control.
  input  wire logic [GAIN_W-1:0]   sine_gain_in,          // Unsigned sine amplitude.
  input  wire logic [CODE_W-1:0]   trap_level_in,         // Trapezoid level from the profile logic.
  input  wire logic                direct_valid_in,       // Direct sample offered.
  input  wire logic [CODE_W-1:0]   direct_data_in,        // Direct sample code.
  output logic                     direct_ready_out,      // Direct sample taken.
  output logic                     generator_enable_out,  // Generator running.
  output logic                     ramp2_done_out,        // Pulse: second ramp finished.
  output logic                     dac_valid_out,         // Sample ready for the converter.
  input  wire logic                dac_ready_in,          // Converter accepts the sample.
  output dwg_sample_t              dac_sample_out         // Sample word.
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  // Two stages so the release edge is clean against clk_sys_in.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) rst_sync_ff <= 2'b00;
    else            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [RAMP2_W-1:0]  ramp2_time_ff, nxt_ramp2_time;
  logic [FREQ_W-1:0]   freq_word_ff, nxt_freq_word;
  logic [PHASE_W-1:0]  phase_off_ff, nxt_phase_off;
  logic [OFFSET_W-1:0] dc_off_ff, nxt_dc_off;
  logic [31:0]         rdata_ff, nxt_rdata;

  // Unmapped addresses read as zero and ignore writes; reserved bits read as zero.
  always_comb begin
    nxt_ramp2_time = ramp2_time_ff;
    nxt_freq_word  = freq_word_ff;
    nxt_phase_off  = phase_off_ff;
    nxt_dc_off     = dc_off_ff;
    nxt_rdata      = rdata_ff;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_RAMP2_TIME:   nxt_ramp2_time = reg_wdata_in[RAMP2_W-1:0];
        ADDR_FREQ_WORD:    nxt_freq_word  = reg_wdata_in[FREQ_W-1:0];
        ADDR_PHASE_OFFSET: nxt_phase_off  = reg_wdata_in[PHASE_W-1:0];
        ADDR_DC_OFFSET:    nxt_dc_off     = reg_wdata_in[OFFSET_W-1:0];
        default:           nxt_dc_off     = dc_off_ff;
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_RAMP2_TIME:   nxt_rdata = {12'h000, ramp2_time_ff};
        ADDR_FREQ_WORD:    nxt_rdata = {8'h00, freq_word_ff};
        ADDR_PHASE_OFFSET: nxt_rdata = {12'h000, phase_off_ff};
        ADDR_DC_OFFSET:    nxt_rdata = {20'h00000, dc_off_ff};
        default:           nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ramp2_time_ff <= RST_RAMP2;
      freq_word_ff  <= RST_FREQ;
      phase_off_ff  <= RST_PHASE;
      dc_off_ff     <= RST_OFFSET;
      rdata_ff      <= 32'h00000000;
    end else begin
      ramp2_time_ff <= nxt_ramp2_time;
      freq_word_ff  <= nxt_freq_word;
      phase_off_ff  <= nxt_phase_off;
      dc_off_ff     <= nxt_dc_off;
      rdata_ff      <= nxt_rdata;
    end
  end
  assign reg_rdata_out = rdata_ff;

  // ---------------------------------------------------------------
  // Quarter-wave sine table
  // ---------------------------------------------------------------
  // Sixteen half-step points keep the table small; spurs are the price.
  function automatic logic signed [CODE_W-1:0] sine_lookup(input logic [PHASE_W-1:0] ph);
    logic [3:0] idx;
    logic [9:0] mag;
    idx = ph[PHASE_W-2] ? ~ph[PHASE_W-3 -: 4] : ph[PHASE_W-3 -: 4];
    unique case (idx)
      4'h0: mag = 10'd50;   4'h1: mag = 10'd150;  4'h2: mag = 10'd248;  4'h3: mag = 10'd345;
      4'h4: mag = 10'd437;  4'h5: mag = 10'd526;  4'h6: mag = 10'd609;  4'h7: mag = 10'd687;
      4'h8: mag = 10'd758;  4'h9: mag = 10'd822;  4'hA: mag = 10'd877;  4'hB: mag = 10'd925;
      4'hC: mag = 10'd963;  4'hD: mag = 10'd992;  4'hE: mag = 10'd1012; 4'hF: mag = 10'd1022;
    endcase
    sine_lookup = ph[PHASE_W-1] ? -$signed({2'b00, mag}) : $signed({2'b00, mag});
  endfunction : sine_lookup

  // ---------------------------------------------------------------
  // Sample sources
  // ---------------------------------------------------------------
  dwg_wave_t                 wave;
  logic [ACC_W-1:0]          acc_ff, nxt_acc;
  logic [9:0]                tick_cnt_ff, nxt_tick_cnt;
  logic                      tick_ff, nxt_tick;
  logic [RAMP2_W-1:0]        ramp_cnt_ff, nxt_ramp_cnt;
  logic                      done_ff, nxt_done, en_ff, nxt_en;
  logic                      trap_pend_ff, nxt_trap_pend;
  logic                      src_valid_ff, nxt_src_valid;
  dwg_sample_t               src_ff, nxt_src;
  logic                      fifo_in_ready, src_take, load_ok;
  logic [PHASE_W-1:0]        phase;
  logic signed [CODE_W-1:0]  sine_raw;
  logic signed [23:0]        product;
  logic signed [CODE_W:0]    sum;
  logic signed [CODE_W-1:0]  sine_code;

  assign wave     = dwg_wave_t'(waveform_type_select_in);
  assign src_take = src_valid_ff && fifo_in_ready;
  assign load_ok  = !src_valid_ff || src_take;
  assign phase    = acc_ff[ACC_W-1 -: PHASE_W] + phase_off_ff;
  assign sine_raw = sine_lookup(phase);
  assign product  = sine_raw * $signed({1'b0, sine_gain_in});
  assign sum      = $signed(product[22:11]) + $signed(dc_off_ff);
  // Saturate rather than wrap, so a large offset clips instead of folding over.
  assign sine_code = (sum > 13'sd2047) ? 12'sh7FF : (sum < -13'sd2048) ? 12'sh800 : sum[CODE_W-1:0];
  assign direct_ready_out = (wave == WAVE_DIRECT) && load_ok;

  // The accumulator only advances when a sine sample is loaded, so a stall loses no phase.
  always_comb begin
    nxt_en        = generator_enable_in || wave == WAVE_SINE || wave == WAVE_TRAP;
    nxt_acc       = acc_ff;
    nxt_tick      = 1'b0;
    nxt_tick_cnt  = tick_cnt_ff + 10'd1;
    nxt_ramp_cnt  = ramp_cnt_ff;
    nxt_done      = 1'b0;
    nxt_trap_pend = trap_pend_ff;
    nxt_src_valid = src_valid_ff && !src_take;
    nxt_src       = src_ff;
    if (tick_cnt_ff == 10'(TRAP_TICK_CYC - 1)) begin
      nxt_tick_cnt = 10'd0;
      nxt_tick     = 1'b1;
    end
    if (wave != WAVE_TRAP) begin
      nxt_ramp_cnt  = '0;
      nxt_trap_pend = 1'b0;
    end else if (tick_ff && en_ff) begin
      nxt_trap_pend = 1'b1;
      if (ramp_cnt_ff < ramp2_time_ff) begin
        nxt_ramp_cnt = ramp_cnt_ff + 20'd1;
        nxt_done     = (ramp_cnt_ff + 20'd1 == ramp2_time_ff);
      end
    end
    if (load_ok) begin
      unique case (wave)
        WAVE_SINE: if (en_ff) begin
          nxt_acc       = acc_ff + {6'h00, freq_word_ff};
          nxt_src_valid = 1'b1;
          nxt_src       = '{src: WAVE_SINE, code: sine_code};
        end
        WAVE_TRAP: if (trap_pend_ff) begin
          // A tick that lands on the load edge stays pending instead of being lost.
          nxt_trap_pend = tick_ff && en_ff;
          nxt_src_valid = 1'b1;
          nxt_src       = '{src: WAVE_TRAP, code: trap_level_in};
        end
        WAVE_DIRECT: if (direct_valid_in) begin
          nxt_src_valid = 1'b1;
          nxt_src       = '{src: WAVE_DIRECT, code: direct_data_in};
        end
        default: nxt_src_valid = src_valid_ff && !src_take;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= '0; tick_cnt_ff <= '0; tick_ff <= 1'b0; ramp_cnt_ff <= '0; done_ff <= 1'b0;
      en_ff <= 1'b0; trap_pend_ff <= 1'b0; src_valid_ff <= 1'b0; src_ff <= '0;
    end else begin
      acc_ff <= nxt_acc; tick_cnt_ff <= nxt_tick_cnt; tick_ff <= nxt_tick; ramp_cnt_ff <= nxt_ramp_cnt;
      done_ff <= nxt_done; en_ff <= nxt_en; trap_pend_ff <= nxt_trap_pend;
      src_valid_ff <= nxt_src_valid; src_ff <= nxt_src;
    end
  end
  assign generator_enable_out = en_ff;
  assign ramp2_done_out       = done_ff;

  // ---------------------------------------------------------------
  // Two-entry output buffer
  // ---------------------------------------------------------------
  dwg_sample_t mem_ff [2];
  dwg_sample_t nxt_mem [2];
  logic        wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [1:0]  cnt_ff, nxt_cnt;
  logic        pop;

  assign fifo_in_ready = (cnt_ff != 2'd2);
  assign pop           = dac_valid_out && dac_ready_in;

  // The source holds its word while the buffer is full, which is the back-pressure path.
  always_comb begin
    nxt_mem = mem_ff;
    nxt_wp  = wp_ff;
    nxt_rp  = rp_ff;
    if (src_take) begin
      nxt_mem[wp_ff] = src_ff;
      nxt_wp         = ~wp_ff;
    end
    if (pop) nxt_rp = ~rp_ff;
    nxt_cnt = 2'(cnt_ff + {1'b0, src_take} - {1'b0, pop});
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      mem_ff <= '{default: '0}; wp_ff <= 1'b0; rp_ff <= 1'b0; cnt_ff <= 2'd0;
    end else begin
      mem_ff <= nxt_mem; wp_ff <= nxt_wp; rp_ff <= nxt_rp; cnt_ff <= nxt_cnt;
    end
  end
  assign dac_valid_out  = (cnt_ff != 2'd0);
  assign dac_sample_out = mem_ff[rp_ff];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Cycles since the last tick; checking the period on a counter keeps the property short.
  logic [9:0] tick_gap_ff, nxt_tick_gap;

  always_comb begin
    nxt_tick_gap = tick_ff ? 10'h001 : tick_gap_ff + 10'h001;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) tick_gap_ff <= 10'h000;
    else        tick_gap_ff <= nxt_tick_gap;
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n);

  a_tick_period: assert property (tick_ff |-> tick_gap_ff == 10'(TRAP_TICK_CYC)) else $error("Trapezoid tick period wrong.");
  a_tick_gap: assert property (tick_ff |=> !tick_ff [*8]) else $error("Trapezoid tick too frequent.");
  a_acc_step: assert property (src_take || !src_valid_ff ##0 (wave == WAVE_SINE && en_ff)
    |=> acc_ff == $past(acc_ff) + {6'h00, $past(freq_word_ff)}) else $error("Accumulator step wrong.");
  a_acc_hold: assert property (src_valid_ff && !fifo_in_ready |=> $stable(acc_ff)) else $error("Phase lost in stall.");
  a_enable_set: assert property (wave inside {WAVE_SINE, WAVE_TRAP} |=> generator_enable_out) else $error("Enable not set.");
  a_freq_write: assert property (reg_wr_in && reg_addr_in == ADDR_FREQ_WORD
    |=> freq_word_ff == $past(reg_wdata_in[23:0])) else $error("Frequency word not stored.");
  a_ramp_done: assert property (ramp2_done_out |-> ramp_cnt_ff == ramp2_time_ff && $past(tick_ff)) else $error("Ramp end wrong.");
  a_offset_read: assert property (reg_rd_in && reg_addr_in == ADDR_DC_OFFSET
    |=> reg_rdata_out == {20'h00000, $past(dc_off_ff)}) else $error("Offset readback wrong.");
  a_buffer_full: assert property (cnt_ff == 2'd2 && !pop |=> cnt_ff == 2'd2 && $stable(dac_sample_out)) else $error("Word lost when full.");
  c_sine_out: cover property (pop && dac_sample_out.src == WAVE_SINE);
  c_trap_out: cover property (pop && dac_sample_out.src == WAVE_TRAP);
  c_full_stall: cover property (cnt_ff == 2'd2 ##1 pop);
  c_ramp_end: cover property (ramp2_done_out);

endmodule : dwg_top

// File: tb/dwg_dac_model.sv
// Converter-side sink for the waveform block: takes samples over valid/ready and logs them.
// Assumes one clock shared with the design and a bench that drives stall_in off the edge.
`timescale 1ns/1ps
module dwg_dac_model
  import dwg_pkg::*;
(
  input  wire logic        clk_in,        // Sample clock.
  input  wire logic        resetn_in,     // Asynchronous reset, active low.
  input  wire logic        stall_in,      // Bench asks the converter to stop taking samples.
  input  wire logic        dac_valid_in,  // Sample offered by the block.
  input  wire dwg_sample_t sample_in,     // Offered sample word.
  output logic             dac_ready_out  // Converter takes a sample this cycle.
);
  // ---------------------------------------------------------------
  // Accepted sample log
  // ---------------------------------------------------------------
  logic [CODE_W-1:0] got[$];
  int                got_cyc[$];
  int                cyc_ff = 0;

  // Ready is registered, so a stall reaches the block one cycle late, as a real converter would.
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dac_ready_out <= 1'h0;
    end else begin
      cyc_ff        <= cyc_ff + 1;
      dac_ready_out <= !stall_in;
      if (dac_valid_in && dac_ready_out) begin
        got.push_back(sample_in.code);
        got_cyc.push_back(cyc_ff);
      end
    end
  end
endmodule : dwg_dac_model

// File: tb/dwg_top_tb.sv
// Self-checking bench for the waveform parameter block: registers, decode, sine, trapezoid, buffer.
// Assumes the converter sink model and a 200 MHz clock; every wait is bounded.
`timescale 1ns/1ps
module dwg_top_tb
  import dwg_pkg::*;
();
  logic              clk_sys_in = 1'h0, resetn_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0, stall = 1'h0;
  logic              direct_valid_in = 1'h0, generator_enable_in = 1'h0;
  logic [15:0]       reg_addr_in = 16'h0000;
  logic [31:0]       reg_wdata_in = 32'h0, reg_rdata_out, rd;
  logic [1:0]        waveform_type_select_in = 2'h0;
  logic [GAIN_W-1:0] sine_gain_in = 11'h000;
  logic [CODE_W-1:0] trap_level_in = 12'h000, direct_data_in = 12'h000;
  logic              direct_ready_out, generator_enable_out, ramp2_done_out, dac_valid_out, dac_ready_in;
  dwg_sample_t       dac_sample_out;
  int                n_fail = 0, tests_run = 0, cyc = 0, done_cyc = -1, base, k, t0;
  int                xing[$];
  logic [15:0]       addrs[4] = '{ADDR_RAMP2_TIME, ADDR_FREQ_WORD, ADDR_PHASE_OFFSET, ADDR_DC_OFFSET};
  logic [31:0]       masks[4] = '{32'h000FFFFF, 32'h00FFFFFF, 32'h000FFFFF, 32'h00000FFF};
  logic [11:0]       dir[6] = '{12'h7FF, 12'h800, 12'h001, 12'h002, 12'hABC, 12'h555};

  dwg_top uut (.clk_sys_in, .resetn_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
    .waveform_type_select_in, .generator_enable_in, .sine_gain_in, .trap_level_in, .direct_valid_in,
    .direct_data_in, .direct_ready_out, .generator_enable_out, .ramp2_done_out, .dac_valid_out,
    .dac_ready_in, .dac_sample_out);
  dwg_dac_model dac (.clk_in(clk_sys_in), .resetn_in, .stall_in(stall), .dac_valid_in(dac_valid_out),
    .sample_in(dac_sample_out), .dac_ready_out(dac_ready_in));

  // ---------------------------------------------------------------
  // Clock, cycle count and done-pulse capture
  // ---------------------------------------------------------------
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (ramp2_done_out) done_cyc <= cyc;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // Register accesses follow the one-cycle strobe protocol; read data lands on the same edge that takes the strobe.
  task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'h1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'h0;
  endtask : reg_write
  task automatic reg_read(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'h1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'h0;
    #1 d = reg_rdata_out;
  endtask : reg_read
  task automatic set_type(input logic [1:0] t);
    @(posedge clk_sys_in);
    waveform_type_select_in <= t;
  endtask : set_type
  task automatic wait_pops(input int n);
    k = 0;
    while (dac.got.size() < base + n) begin
      @(posedge clk_sys_in);
      k++;
      if (k > 5000) begin
        n_fail++;
        $display("ERROR at %0t: wait limit reached", $time);
        complete_run();
      end
    end
  endtask : wait_pops
  // Holds the offer until ready is seen settled before the taking edge.
  task automatic push_direct(input logic [11:0] d);
    direct_valid_in <= 1'h1;
    direct_data_in <= d;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_sys_in);
      if (direct_ready_out) break;
      if (i == 299) begin
        n_fail++;
        $display("ERROR at %0t: ready wait limit reached", $time);
        complete_run();
      end
    end
    @(posedge clk_sys_in);
  endtask : push_direct
  // Offsets and gain go in while idle, then sine is selected; a constant phase gives a steady code.
  task automatic sine_case(input logic [19:0] ph, input logic [10:0] g, input logic [11:0] off,
                           input int lo, input int hi);
    set_type(2'h0);
    reg_write(ADDR_PHASE_OFFSET, {12'h000, ph});
    reg_write(ADDR_DC_OFFSET, {20'h00000, off});
    sine_gain_in <= g;
    set_type(2'h2);
    repeat (30) @(posedge clk_sys_in);
    k = $signed(dac.got[dac.got.size() - 1]);
    check(k >= lo && k <= hi, 32'h1);
  endtask : sine_case

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys_in);
    resetn_in <= 1'h1;
    repeat (3) @(posedge clk_sys_in);
    for (int i = 0; i < 4; i++) begin
      reg_read(addrs[i], rd);
      check(rd, 32'h0);
      reg_write(addrs[i], 32'hFFFFFFFF);
      reg_read(addrs[i], rd);
      check(rd, masks[i]);
      reg_write(addrs[i], 32'h0);
    end
    reg_write(16'h2040, 32'hFFFFFFFF);
    reg_read(16'h2040, rd);
    check(rd, 32'h0);
    for (int t = 0; t < 4; t++) begin
      set_type(t[1:0]);
      repeat (3) @(posedge clk_sys_in);
      check({31'h0, generator_enable_out}, {31'h0, t[1]});
    end
    set_type(2'h0);
    generator_enable_in <= 1'h1;
    repeat (3) @(posedge clk_sys_in);
    check({31'h0, generator_enable_out}, 32'h1);
    generator_enable_in <= 1'h0;
    sine_case(20'h00000, 11'h000, 12'hF9C, -100, -100);
    sine_case(20'h40000, 11'h7FF, 12'h000, 1001, 1023);
    sine_case(20'hC0000, 11'h7FF, 12'h000, -1023, -1001);
    sine_case(20'h40000, 11'h400, 12'h064, 580, 630);
    // A word of 2^20 gives exactly 1024 steps a period, whole periods in a 1024-point transform.
    sine_case(20'h00000, 11'h7FF, 12'h000, 0, 100);
    set_type(2'h0);
    reg_write(ADDR_FREQ_WORD, 32'h00100000);
    base = dac.got.size();
    set_type(2'h2);
    wait_pops(2600);
    for (int i = base + 1; i < dac.got.size(); i++)
      if ($signed(dac.got[i - 1]) < 0 && $signed(dac.got[i]) >= 0) xing.push_back(i);
    check(xing[1] - xing[0], 32'd1024);
    // The converter stalls while six direct words are offered; none may be lost or reordered.
    // Let leftover sine words drain before the stall, so only direct words are counted.
    set_type(2'h0);
    repeat (5) @(posedge clk_sys_in);
    stall <= 1'h1;
    repeat (5) @(posedge clk_sys_in);
    base = dac.got.size();
    fork
      begin
        for (int i = 0; i < 6; i++) push_direct(dir[i]);
        direct_valid_in <= 1'h0;
      end
      begin
        repeat (40) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check({31'h0, direct_ready_out}, 32'h0);
        check({31'h0, dac_valid_out}, 32'h1);
        @(posedge clk_sys_in);
        stall <= 1'h0;
      end
    join
    wait_pops(6);
    for (int i = 0; i < 6; i++) check({20'h0, dac.got[base + i]}, {20'h0, dir[i]});
    reg_write(ADDR_RAMP2_TIME, 32'h3);
    trap_level_in <= 12'h3A5;
    base = dac.got.size();
    set_type(2'h3);
    t0 = cyc;
    wait_pops(3);
    check(dac.got_cyc[base + 2] - dac.got_cyc[base + 1], 32'd625);
    check({20'h0, dac.got[base + 2]}, 32'h3A5);
    repeat (2000) @(posedge clk_sys_in);
    check(done_cyc - t0 >= 1240 && done_cyc - t0 <= 1900, 32'h1);
    complete_run();
  end
endmodule : dwg_top_tb
